//--- verilog/psc_defs.vh
// Register map, reset values, write masks and timing constants of the sequencer
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
`define PSC_ADDR_CLKERR 8'h04
`define PSC_ADDR_CHARGE 8'h05
`define PSC_ADDR_DEPOP 8'h06
`define PSC_ADDR_DAC 8'h07
`define PSC_RST_CLKERR 8'h00
`define PSC_RST_CHARGE 8'h15
`define PSC_RST_DEPOP 8'h35
`define PSC_RST_DAC 8'h00
`define PSC_MASK_CLKERR 8'h42
`define PSC_MASK_CHARGE 8'hFC
`define PSC_MASK_DEPOP 8'hFF
`define PSC_MASK_DAC 8'hF0
`define PSC_CLK_HZ 10000000
`define PSC_TICK_US 100
`define PSC_TICK_CYC (`PSC_CLK_HZ / 1000000 * `PSC_TICK_US)
`define PSC_CLKLOSS_US 2000
`define PSC_CLKLOSS_TICKS (`PSC_CLKLOSS_US / `PSC_TICK_US)
// Sequence lengths in time base ticks
`define PSC_DIS_LEN 16'h0019
`define PSC_QCHG0_LEN 16'h0019
`define PSC_QCHG1_LEN 16'h007D
`define PSC_QCHG2_LEN 16'h00FA
`define PSC_QCHG3_LEN 16'h01F4
`define PSC_HOLD0_LEN 16'h012C
`define PSC_HOLD1_LEN 16'h00FA
`define PSC_HOLD2_LEN 16'h0064
`define PSC_HOLD3_LEN 16'h0032
`define PSC_HPC0_LEN 16'h0014
`define PSC_HPC1_LEN 16'h0028
`define PSC_HPC2_LEN 16'h0050
`define PSC_HPC3_LEN 16'h00A0
`define PSC_HPC4_LEN 16'h01F4
`define PSC_HPC5_LEN 16'h03E8
`define PSC_HPC6_LEN 16'h09C4
`define PSC_HPC7_LEN 16'h1388
`define PSC_HPC8_LEN 16'h2710
`define PSC_HPC9_LEN 16'hC350
`define PSC_LATE0_LEN 16'h0280
`define PSC_LATE1_LEN 16'h0A00
`endif

//--- verilog/psc_timer.v
// Restartable tick counter that pulses once a programmed length expires
`default_nettype none
module psc_timer #(
    parameter W = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire start,
    input wire tick,
    input wire [W-1:0] length,
    // Result
    output reg busy_ff,
    output reg done_ff
);
    reg [W-1:0] cnt_ff;
    // Count ticks; a start always reloads, even mid-run
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= {W{1'b0}};
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                cnt_ff <= length;
                busy_ff <= 1'b1;
            end else if (busy_ff && tick) begin
                if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/psc_top.v
// Power sequence configuration registers and sequencing timers
`include "psc_defs.vh"
`default_nettype none
module psc_top #(
    parameter TICK_CYC = `PSC_TICK_CYC,
    parameter [6:0] GROUP_ADDR = 7'h50 // Arbitrary value
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    // Software reset pulse
    input wire soft_reset,
    // Address pins
    input wire [1:0] addr_pins,
    // Events from outside logic
    input wire clock_error,
    input wire clock_present,
    input wire io_supply_good,
    input wire clean_shutdown_done,
    input wire input_charge_req,
    input wire dac_power_req,
    // Outputs
    output reg [6:0] target_address_ff,
    output reg clock_error_action_ff,
    output reg core_regulator_on_ff,
    output reg input_cap_fast_charge_ff,
    output reg [1:0] antipop_resistor_stage_a_ff,
    output reg [1:0] antipop_resistor_stage_b_ff,
    output reg headphone_cap_charge_ff,
    output reg dac_cap_discharge_ff,
    output reg dac_power_on_ff,
    output reg hard_reset_ff
);
    ////////////////////////////////////////////////////////////////////////
    reg rst_s1_ff, rst_s2_ff;
    wire rst_n = rst_s2_ff;
    // Reset release through two flops
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Pin synchronisers: change counts once stages two and three agree
    reg [2:0] clkp_ff, supp_ff;
    reg clkp_ok_ff, supp_ok_ff;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkp_ff <= 3'h7;
            supp_ff <= 3'h7;
            clkp_ok_ff <= 1'b1;
            supp_ok_ff <= 1'b1;
        end else begin
            clkp_ff <= {clkp_ff[1:0], clock_present};
            supp_ff <= {supp_ff[1:0], io_supply_good};
            if (clkp_ff[1] == clkp_ff[2])
                clkp_ok_ff <= clkp_ff[2];
            if (supp_ff[1] == supp_ff[2])
                supp_ok_ff <= supp_ff[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 us time base
    reg [15:0] div_ff;
    reg tick_ff;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (div_ff >= TICK_CYC - 1) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; reserved bits masked on write only, reset values stored as given
    reg [7:0] clkerr_ff, charge_ff, depop_ff, dac_ff;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkerr_ff <= `PSC_RST_CLKERR;
            charge_ff <= `PSC_RST_CHARGE;
            depop_ff <= `PSC_RST_DEPOP;
            dac_ff <= `PSC_RST_DAC;
        end else if (soft_reset) begin
            clkerr_ff <= `PSC_RST_CLKERR;
            charge_ff <= `PSC_RST_CHARGE;
            depop_ff <= `PSC_RST_DEPOP;
            dac_ff <= `PSC_RST_DAC;
        end else if (reg_wr) begin
            case (reg_addr)
                `PSC_ADDR_CLKERR: clkerr_ff <= reg_wdata & `PSC_MASK_CLKERR;
                `PSC_ADDR_CHARGE: charge_ff <= reg_wdata & `PSC_MASK_CHARGE;
                `PSC_ADDR_DEPOP: depop_ff <= reg_wdata & `PSC_MASK_DEPOP;
                `PSC_ADDR_DAC: dac_ff <= reg_wdata & `PSC_MASK_DAC;
                default: ;
            endcase
        end
    end

    // Read data held until next read; unmapped reads zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_ff <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `PSC_ADDR_CLKERR: reg_rdata_ff <= clkerr_ff;
                `PSC_ADDR_CHARGE: reg_rdata_ff <= charge_ff;
                `PSC_ADDR_DEPOP: reg_rdata_ff <= depop_ff;
                `PSC_ADDR_DAC: reg_rdata_ff <= dac_ff;
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    wire ignore_clk_err = clkerr_ff[6];
    wire group_address_enable = clkerr_ff[1];
    wire [1:0] input_cap_fast_charge_time = charge_ff[7:6];
    wire [1:0] power_down_policy = charge_ff[5:4];
    wire [1:0] core_regulator_hold_time = charge_ff[3:2];
    wire [3:0] headphone_cap_charge_time = depop_ff[3:0];
    wire dac_cap_discharge_start = dac_ff[7];
    wire dac_late_power_on = dac_ff[6];
    wire dac_late_power_on_delay = dac_ff[5];
    wire clock_loss_hard_reset_enable = dac_ff[4];

    ////////////////////////////////////////////////////////////////////////
    // Durations in 100 us ticks
    reg [15:0] qchg_len, hold_len, hpc_len, late_len;
    always @* begin
        case (input_cap_fast_charge_time)
            2'h0: qchg_len = `PSC_QCHG0_LEN;
            2'h1: qchg_len = `PSC_QCHG1_LEN;
            2'h2: qchg_len = `PSC_QCHG2_LEN;
            default: qchg_len = `PSC_QCHG3_LEN;
        endcase
        case (core_regulator_hold_time)
            2'h0: hold_len = `PSC_HOLD0_LEN;
            2'h1: hold_len = `PSC_HOLD1_LEN;
            2'h2: hold_len = `PSC_HOLD2_LEN;
            default: hold_len = `PSC_HOLD3_LEN;
        endcase
        case (headphone_cap_charge_time)
            4'h0: hpc_len = `PSC_HPC0_LEN;
            4'h1: hpc_len = `PSC_HPC1_LEN;
            4'h2: hpc_len = `PSC_HPC2_LEN;
            4'h3: hpc_len = `PSC_HPC3_LEN;
            4'h4: hpc_len = `PSC_HPC4_LEN;
            4'h5: hpc_len = `PSC_HPC5_LEN;
            4'h6: hpc_len = `PSC_HPC6_LEN;
            4'h7: hpc_len = `PSC_HPC7_LEN;
            4'h8: hpc_len = `PSC_HPC8_LEN;
            default: hpc_len = `PSC_HPC9_LEN; // Codes above 9 act as 5 s
        endcase
        // Lower end of each range, guaranteed minimum
        late_len = dac_late_power_on_delay ? `PSC_LATE1_LEN :
            `PSC_LATE0_LEN;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event edges
    reg supp_d_ff, chg_d_ff, dac_d_ff, clkp_d_ff;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            supp_d_ff <= 1'b1;
            chg_d_ff <= 1'b0;
            dac_d_ff <= 1'b0;
        end else begin
            supp_d_ff <= supp_ok_ff;
            chg_d_ff <= input_charge_req;
            dac_d_ff <= dac_power_req;
        end
    end
    wire supply_lost = supp_d_ff & ~supp_ok_ff;
    wire chg_start = input_charge_req & ~chg_d_ff;
    wire dac_start = dac_power_req & ~dac_d_ff;

    // DAC sequence: discharge, delay, headphone charge, on
    localparam S_IDLE = 3'h0, S_DIS = 3'h1, S_LATE = 3'h2;
    localparam S_HPC = 3'h3, S_ON = 3'h4;
    reg [2:0] st_ff, nxt_st;
    wire dis_done, late_done, hpc_done, qchg_busy, hold_done, loss_done;
    wire qchg_busy_w, hpc_busy;
    reg t_dis, t_late, t_hpc;
    always @* begin
        nxt_st = st_ff;
        t_dis = 1'b0;
        t_late = 1'b0;
        t_hpc = 1'b0;
        case (st_ff)
            S_IDLE: if (dac_start) begin
                if (dac_cap_discharge_start) begin
                    nxt_st = S_DIS;
                    t_dis = 1'b1;
                end else if (dac_late_power_on) begin
                    nxt_st = S_LATE;
                    t_late = 1'b1;
                end else begin
                    nxt_st = S_HPC;
                    t_hpc = 1'b1;
                end
            end
            S_DIS: if (dis_done) begin
                if (dac_late_power_on) begin
                    nxt_st = S_LATE;
                    t_late = 1'b1;
                end else begin
                    nxt_st = S_HPC;
                    t_hpc = 1'b1;
                end
            end
            S_LATE: if (late_done) begin
                nxt_st = S_HPC;
                t_hpc = 1'b1;
            end
            S_HPC: if (hpc_done) nxt_st = S_ON;
            S_ON: ;
            default: nxt_st = S_IDLE;
        endcase
        if (!dac_power_req) nxt_st = S_IDLE;
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) st_ff <= S_IDLE;
        else st_ff <= nxt_st;
    end

    localparam [31:0] LOSS_TICKS = `PSC_CLKLOSS_TICKS;
    // Timers; discharge uses the fixed PSC_DIS_LEN, equal to the shortest fast-charge length of input caps
    psc_timer #(.W(16)) u_dis (.clk(ref_clk), .rst_n(rst_n),
        .start(t_dis), .tick(tick_ff), .length(`PSC_DIS_LEN),
        .busy_ff(), .done_ff(dis_done));
    psc_timer #(.W(16)) u_late (.clk(ref_clk), .rst_n(rst_n),
        .start(t_late), .tick(tick_ff), .length(late_len),
        .busy_ff(), .done_ff(late_done));
    psc_timer #(.W(16)) u_hpc (.clk(ref_clk), .rst_n(rst_n),
        .start(t_hpc), .tick(tick_ff), .length(hpc_len),
        .busy_ff(hpc_busy), .done_ff(hpc_done));
    psc_timer #(.W(16)) u_qchg (.clk(ref_clk), .rst_n(rst_n),
        .start(chg_start), .tick(tick_ff), .length(qchg_len),
        .busy_ff(qchg_busy_w), .done_ff());
    psc_timer #(.W(16)) u_hold (.clk(ref_clk), .rst_n(rst_n),
        .start(supply_lost), .tick(tick_ff), .length(hold_len),
        .busy_ff(), .done_ff(hold_done));
    // Any change of clock presence restarts, so a stale count never fires
    psc_timer #(.W(16)) u_loss (.clk(ref_clk), .rst_n(rst_n),
        .start(clkp_ok_ff != clkp_d_ff), .tick(tick_ff),
        .length(LOSS_TICKS[15:0]), .busy_ff(), .done_ff(loss_done));
    assign qchg_busy = qchg_busy_w;

    // Regulator and outputs
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkp_d_ff <= 1'b1;
            core_regulator_on_ff <= 1'b1;
            hard_reset_ff <= 1'b0;
            target_address_ff <= 7'h00;
            clock_error_action_ff <= 1'b0;
            input_cap_fast_charge_ff <= 1'b0;
            antipop_resistor_stage_a_ff <= 2'h0;
            antipop_resistor_stage_b_ff <= 2'h0;
            headphone_cap_charge_ff <= 1'b0;
            dac_cap_discharge_ff <= 1'b0;
            dac_power_on_ff <= 1'b0;
        end else begin
            clkp_d_ff <= clkp_ok_ff;
            if (supp_ok_ff)
                core_regulator_on_ff <= 1'b1;
            else if (supply_lost && power_down_policy == 2'h0)
                core_regulator_on_ff <= 1'b0;
            else if (hold_done && power_down_policy == 2'h1)
                core_regulator_on_ff <= 1'b0;
            else if (clean_shutdown_done)
                core_regulator_on_ff <= 1'b0;
            // Held while enabled and clock still missing
            hard_reset_ff <= clock_loss_hard_reset_enable & ~clkp_ok_ff &
                (hard_reset_ff | loss_done);
            target_address_ff <= group_address_enable ?
                {GROUP_ADDR[6:2], 2'b00} :
                {GROUP_ADDR[6:2], addr_pins};
            clock_error_action_ff <= clock_error & ~ignore_clk_err;
            input_cap_fast_charge_ff <= qchg_busy;
            antipop_resistor_stage_a_ff <= depop_ff[7:6];
            antipop_resistor_stage_b_ff <= depop_ff[5:4];
            headphone_cap_charge_ff <= hpc_busy;
            dac_cap_discharge_ff <= (nxt_st == S_DIS);
            dac_power_on_ff <= (nxt_st == S_ON);
        end
    end
endmodule
`default_nettype wire

//--- tb/psc_top_sva.sv
// Port-level assertions for the power sequence configuration block
`include "psc_defs.vh"
`default_nettype none
module psc_top_chk #(
    parameter TICK_CYC = `PSC_TICK_CYC,
    parameter [6:0] GROUP_ADDR = 7'h50
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic soft_reset,
    // Pins and events
    input wire logic [1:0] addr_pins,
    input wire logic clock_error,
    input wire logic clock_present,
    input wire logic io_supply_good,
    input wire logic input_charge_req,
    input wire logic dac_power_req,
    // Outputs
    input wire logic [6:0] target_address_ff,
    input wire logic clock_error_action_ff,
    input wire logic core_regulator_on_ff,
    input wire logic input_cap_fast_charge_ff,
    input wire logic [1:0] antipop_resistor_stage_a_ff,
    input wire logic [1:0] antipop_resistor_stage_b_ff,
    input wire logic dac_cap_discharge_ff,
    input wire logic hard_reset_ff
);
    localparam [15:0] LATE = 22 * TICK_CYC + 8;
    localparam [31:0] MSK = {`PSC_MASK_DAC, `PSC_MASK_DEPOP,
        `PSC_MASK_CHARGE, `PSC_MASK_CLKERR};
    logic [7:0] sh_ff [0:3];
    logic [3:0] rdy_ff;
    logic [15:0] lost_ff;
    wire hit = reg_addr[7:2] == 6'h01;
    wire [7:0] rd_exp = hit ? sh_ff[reg_addr[1:0]] : 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // Shadow registers, masked as the hardware stores them
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_ff[0] <= `PSC_RST_CLKERR;
            sh_ff[1] <= `PSC_RST_CHARGE;
            sh_ff[2] <= `PSC_RST_DEPOP;
            sh_ff[3] <= `PSC_RST_DAC;
        end else if (soft_reset) begin
            sh_ff[0] <= `PSC_RST_CLKERR;
            sh_ff[1] <= `PSC_RST_CHARGE;
            sh_ff[2] <= `PSC_RST_DEPOP;
            sh_ff[3] <= `PSC_RST_DAC;
        end else if (reg_wr && hit) begin
            sh_ff[reg_addr[1:0]] <=
                reg_wdata & MSK[{reg_addr[1:0], 3'h0} +: 8];
        end
    end
    // Wait out the reset synchroniser before judging outputs
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_ff <= 4'h0;
            lost_ff <= 16'h0000;
        end else begin
            rdy_ff <= {rdy_ff[2:0], 1'b1};
            lost_ff <= clock_present ? 16'h0000 : lost_ff + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rdy_ff[3]);
    property p_rd; reg_rd |=> reg_rdata_ff == $past(rd_exp); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_err;
        clock_error_action_ff == $past(clock_error && !sh_ff[0][6]);
    endproperty
    a_err: assert property (p_err) else $error("error action wrong");
    property p_grp;
        target_address_ff ==
            {GROUP_ADDR[6:2], $past(sh_ff[0][1] ? 2'h0 : addr_pins)};
    endproperty
    a_grp: assert property (p_grp) else $error("target address wrong");
    property p_dep; $stable(sh_ff[2]) |-> {antipop_resistor_stage_a_ff,
        antipop_resistor_stage_b_ff} == sh_ff[2][7:4]; endproperty
    a_dep: assert property (p_dep) else $error("resistor code wrong");
    property p_pol0; $fell(io_supply_good) && sh_ff[1][5:4] == 2'h0
        |-> ##[1:8] !core_regulator_on_ff; endproperty
    a_pol0: assert property (p_pol0) else $error("regulator kept on");
    property p_inc;
        $rose(input_charge_req) |-> ##[1:6] input_cap_fast_charge_ff;
    endproperty
    a_inc: assert property (p_inc) else $error("no fast charge");
    property p_dis; $rose(dac_power_req) && sh_ff[3][7]
        |-> ##[1:6] dac_cap_discharge_ff; endproperty
    a_dis: assert property (p_dis) else $error("no discharge");
    property p_hr;
        sh_ff[3][4] && lost_ff == LATE |-> hard_reset_ff;
    endproperty
    a_hr: assert property (p_hr) else $error("no hard reset");
endmodule
bind psc_top psc_top_chk #(.TICK_CYC(TICK_CYC), .GROUP_ADDR(GROUP_ADDR))
    i_psc_top_chk (.*);
`default_nettype wire

//--- tb/psc_top_tb_top.sv
// Self-checking bench for the power sequence configuration block
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module psc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 2;
    logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, soft_reset = 0;
    logic clock_error = 0, clock_present = 1, io_supply_good = 1;
    logic clean_shutdown_done = 0, input_charge_req = 0, dac_power_req = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_ff;
    logic [1:0] addr_pins = 0, antipop_resistor_stage_a_ff;
    logic [1:0] antipop_resistor_stage_b_ff;
    logic [6:0] target_address_ff;
    logic clock_error_action_ff, core_regulator_on_ff, dac_power_on_ff;
    logic input_cap_fast_charge_ff, headphone_cap_charge_ff, hard_reset_ff;
    logic dac_cap_discharge_ff;
    int fails = 0, tests_run = 0, n;
    logic [7:0] rv [5] = '{8'h00, 8'h15, 8'h35, 8'h00, 8'h00};
    // Legal values only: reserved bits and codes stay untouched
    logic [7:0] mk [5] = '{8'h42, 8'hE8, 8'hE9, 8'hF0, 8'h00};
    logic [7:0] dc [3] = '{8'hC0, 8'h60, 8'h20};
    int qc [4] = '{25, 125, 250, 500};
    int ka [4] = '{300, 250, 100, 50};
    int dl [3] = '{665, 2560, 0};
    int hp [9] = '{20, 40, 80, 160, 500, 1000, 2500, 5000, 10000};
    // Short tick keeps the long sequences inside the run budget
    psc_top #(.TICK_CYC(TK)) i_psc_top (.*);
    initial forever #50 ref_clk = ~ref_clk;
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 0;
        `CHK("register", e, reg_rdata_ff)
    endtask
    function automatic logic obs(input int i);
        case (i)
            0: return input_cap_fast_charge_ff;
            1: return headphone_cap_charge_ff;
            3: return dac_power_on_ff;
            4: return !core_regulator_on_ff;
            default: return hard_reset_ff;
        endcase
    endfunction
    // Bounded wait for an output level
    task automatic wait_lvl(input int i, input logic v);
        n = 0;
        while (obs(i) !== v && n < 30000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // Tolerance covers free-running tick phase and input synchronisers
    task automatic dur(input int i, input logic v, input int e);
        wait_lvl(i, v);
        `CHK("duration", 1'b1, n >= e - TK - 1 && n <= e + TK + 6)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge ref_clk);
        arst_n = 1;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 + i), rv[i]);
            wr(8'(4 + i), i < 4 ? mk[i] : 8'hFF);
            rd(8'(4 + i), mk[i]);
        end
        soft_reset = 1;
        @(negedge ref_clk);
        soft_reset = 0;
        rd(8'h05, 8'h15);
        clock_error = 1;
        addr_pins = 2'h3;
        repeat (3) @(negedge ref_clk);
        `CHK("error action", 1'b1, clock_error_action_ff)
        `CHK("target", 7'h53, target_address_ff)
        wr(8'h04, 8'h42);
        repeat (2) @(negedge ref_clk);
        `CHK("error action", 1'b0, clock_error_action_ff)
        `CHK("target", 7'h50, target_address_ff)
        clock_error = 0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h06, {i[1:0], 2'(3 - i), 4'h0});
            repeat (2) @(negedge ref_clk);
            `CHK("stage a", i[1:0], antipop_resistor_stage_a_ff)
            `CHK("stage b", 2'(3 - i), antipop_resistor_stage_b_ff)
            wr(8'h05, {i[1:0], 6'h14});
            input_charge_req = 1;
            wait_lvl(0, 1);
            dur(0, 0, qc[i] * TK);
            input_charge_req = 0;
            wr(8'h05, {4'h1, i[1:0], 2'h0});
            io_supply_good = 0;
            dur(4, 1, ka[i] * TK);
            io_supply_good = 1;
            wait_lvl(4, 0);
        end
        for (int i = 0; i < 12; i++) begin
            wr(8'h06, i < 9 ? 8'(i) : 8'h00);
            if (i > 8) wr(8'h07, dc[i - 9]);
            dac_power_req = 1;
            if (i > 8) dur(1, 1, dl[i - 9] * TK);
            dur(3, 1, hp[i < 9 ? i : 0] * TK);
            dac_power_req = 0;
            repeat (2) @(negedge ref_clk);
        end
        wr(8'h05, 8'h00);
        io_supply_good = 0;
        dur(4, 1, 0);
        io_supply_good = 1;
        wait_lvl(4, 0);
        wr(8'h05, 8'h20);
        io_supply_good = 0;
        repeat (800) @(negedge ref_clk);
        `CHK("regulator", 1'b1, core_regulator_on_ff)
        clean_shutdown_done = 1;
        dur(4, 1, 0);
        clean_shutdown_done = 0;
        io_supply_good = 1;
        wr(8'h07, 8'h10);
        clock_present = 0;
        repeat (30) @(negedge ref_clk);
        `CHK("hard reset", 1'b0, hard_reset_ff)
        clock_present = 1;
        repeat (10) @(negedge ref_clk);
        clock_present = 0;
        dur(5, 1, 20 * TK);
        // Keep the clock away past the checker's loss window
        repeat (12) @(negedge ref_clk);
        clock_present = 1;
        wait_lvl(5, 0);
        wr(8'h07, 8'h00);
        clock_present = 0;
        repeat (100) @(negedge ref_clk);
        `CHK("hard reset", 1'b0, hard_reset_ff)
        end_of_test;
    end
endmodule
`default_nettype wire
